/* rtl/hcr_pkg.sv */
// Overview of operation
// - function 11 falling edge: clear, open gate
// - function 11 rising edge: capture, close gate
// - function 5 rising edge: reset, keep counting
// - count inside configured range sets bit
// - counter and capture are 32 bits
// - pulse output held for configured duration
// - switch off simple, on linear/circular
// - combining ANDs both channel patterns
package hcr_pkg;
	// ----------------------------------------
	// widths and codes
	// ----------------------------------------
	localparam int CNT_W = 32; // count width
	localparam int NRANGE = 2; // ranges per channel
	localparam int NOUT = 2; // output bits
	localparam int FUNC_W = 4; // input function code width
	localparam logic [3:0] FUNC_NONE = 4'h0; // no function
	localparam logic [3:0] FUNC_RESET_RISE = 4'h5; // reset on rising edge
	localparam logic [3:0] FUNC_RSCC = 4'hb; // reset, stop, capture, continue
	localparam logic [31:0] CNT_RESET = 32'h0000_0000; // count reset value
	localparam logic [31:0] PULSE_DEF = 32'h0000_0001; // default pulse cycles

	// one range of a channel
	typedef struct packed {
		logic [31:0] low; // inclusive lower bound
		logic [31:0] high; // inclusive upper bound
		logic [1:0] set_mask; // output bits this range sets
	} hcr_range_s;

	// host controls of one channel
	typedef struct packed {
		logic sw_reset; // software reset pulse
		logic gate_open; // software gate open pulse
		logic gate_close; // software gate close pulse
	} hcr_ctl_s;
endpackage

/* rtl/hcr_sync.sv */
`timescale 1ns/100ps
// two-flop synchroniser with edge outputs
module hcr_sync (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic din,
	output logic level,
	output logic rise,
	output logic fall
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic meta; // first stage, read only by second
	logic stable; // second stage
	logic prev; // delayed copy for edges
	logic next_meta;
	logic next_stable;
	logic next_prev;

	// next values
	always_comb begin
		next_meta = din;
		next_stable = meta;
		next_prev = stable;
	end

	// registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b0;
			stable <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= next_meta;
			stable <= next_stable;
			prev <= next_prev;
		end
	end

	// edges from the stable stages only
	assign level = stable;
	assign rise = stable & ~prev;
	assign fall = ~stable & prev;
endmodule

/* rtl/hcr_top.sv */
`timescale 1ns/100ps
// one counter channel with input functions, range outputs and capture
module hcr_top #(
	parameter logic [31:0] PULSE_CYCLES = hcr_pkg::PULSE_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic count_pulse, // encoder pulse pin
	input wire logic first_digital_input, // sensor pin
	input wire logic [3:0] input_function, // function of the input
	input wire logic mode_switch, // off simple, on linear/circular
	input wire hcr_pkg::hcr_ctl_s host_ctl, // host reset and gate pulses
	input wire hcr_pkg::hcr_range_s range0, // range 0 configuration
	input wire hcr_pkg::hcr_range_s range1, // range 1 configuration
	input wire logic [1:0] pulse_mode, // bit held for pulse duration
	input wire logic combine_en, // and with other channel pattern
	input wire logic [1:0] other_pattern, // pattern of other channel
	input wire logic unit_read_command, // host read request pulse
	output logic [31:0] count_value, // live count
	output logic [31:0] read_data, // captured value on read
	output logic read_valid, // read answer strobe
	output logic gate_state, // gate is open
	output logic [1:0] output_pattern, // this channel pattern
	output logic [1:0] first_digital_output // driven output bits
);
	// ----------------------------------------
	// input conditioning
	// ----------------------------------------
	logic pin_rise; // input rising edge
	logic pin_fall; // input falling edge
	logic cnt_rise; // counted pulse edge

	// sensor input
	hcr_sync u_pin (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.din(first_digital_input),
		.level(),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// encoder pulse input
	hcr_sync u_cnt (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.din(count_pulse),
		.level(),
		.rise(cnt_rise),
		.fall()
	);

	// ----------------------------------------
	// counter, gate and capture
	// ----------------------------------------
	logic [31:0] capture; // captured count
	logic [31:0] next_count;
	logic [31:0] next_capture;
	logic next_gate;
	logic [31:0] next_read_data;
	logic next_read_valid;
	logic fn_active; // input functions only with switch on

	// count, gate and capture next values
	always_comb begin
		fn_active = mode_switch;
		next_count = count_value;
		next_capture = capture;
		next_gate = gate_state;
		next_read_data = read_data;
		next_read_valid = 1'b0;
		// closed gate holds the count
		if (gate_state && cnt_rise) begin
			next_count = count_value + 32'h0000_0001;
		end
		// host controls, active in both switch settings
		if (host_ctl.gate_close) begin
			next_gate = 1'b0;
		end
		if (host_ctl.gate_open) begin
			next_gate = 1'b1;
		end
		if (host_ctl.sw_reset) begin
			next_count = hcr_pkg::CNT_RESET;
		end
		// digital input functions
		if (fn_active && input_function == hcr_pkg::FUNC_RSCC) begin
			if (pin_fall) begin
				next_count = hcr_pkg::CNT_RESET;
				next_gate = 1'b1;
			end
			if (pin_rise) begin
				next_capture = count_value;
				next_gate = 1'b0;
			end
		end
		if (fn_active && input_function == hcr_pkg::FUNC_RESET_RISE && pin_rise) begin
			next_count = hcr_pkg::CNT_RESET;
		end
		// captured value only answers an explicit read
		if (unit_read_command) begin
			next_read_data = capture;
			next_read_valid = 1'b1;
		end
	end

	// count registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_value <= hcr_pkg::CNT_RESET;
			capture <= hcr_pkg::CNT_RESET;
			gate_state <= 1'b0;
			read_data <= hcr_pkg::CNT_RESET;
			read_valid <= 1'b0;
		end else begin
			count_value <= next_count;
			capture <= next_capture;
			gate_state <= next_gate;
			read_data <= next_read_data;
			read_valid <= next_read_valid;
		end
	end

	// ----------------------------------------
	// range comparison and outputs
	// ----------------------------------------
	// inclusive range test
	function automatic logic in_range(input logic [31:0] v, input hcr_pkg::hcr_range_s r);
		in_range = (v >= r.low) && (v <= r.high);
	endfunction

	logic [1:0] level_pat; // range-driven pattern
	logic [1:0] prev_level; // pattern one cycle ago
	logic [1:0] pulse_pat; // pulse-shaped pattern
	logic [31:0] pulse_cnt [2]; // remaining pulse cycles
	logic [1:0] next_pattern;
	logic [1:0] next_out;
	logic [1:0] next_pulse_pat;
	logic [31:0] next_pulse_cnt [2];
	logic [1:0] eff_pat; // pattern after pulse shaping

	// pattern, pulse timers and combining
	always_comb begin
		level_pat = 2'h0;
		if (in_range(count_value, range0)) begin
			level_pat = level_pat | range0.set_mask;
		end
		if (in_range(count_value, range1)) begin
			level_pat = level_pat | range1.set_mask;
		end
		next_pulse_pat = pulse_pat;
		for (int i = 0; i < 2; i++) begin
			next_pulse_cnt[i] = pulse_cnt[i];
			if (level_pat[i] && !prev_level[i]) begin
				next_pulse_cnt[i] = PULSE_CYCLES;
				next_pulse_pat[i] = 1'b1;
			end else if (pulse_cnt[i] > 32'h0000_0001) begin
				next_pulse_cnt[i] = pulse_cnt[i] - 32'h0000_0001;
			end else begin
				next_pulse_cnt[i] = 32'h0000_0000;
				next_pulse_pat[i] = 1'b0;
			end
		end
		eff_pat = (level_pat & ~pulse_mode) | (pulse_pat & pulse_mode);
		next_pattern = eff_pat;
		next_out = combine_en ? (eff_pat & other_pattern) : eff_pat;
	end

	// output registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_level <= 2'h0;
			pulse_pat <= 2'h0;
			pulse_cnt[0] <= 32'h0000_0000;
			pulse_cnt[1] <= 32'h0000_0000;
			output_pattern <= 2'h0;
			first_digital_output <= 2'h0;
		end else begin
			prev_level <= level_pat;
			pulse_pat <= next_pulse_pat;
			pulse_cnt[0] <= next_pulse_cnt[0];
			pulse_cnt[1] <= next_pulse_cnt[1];
			output_pattern <= next_pattern;
			first_digital_output <= next_out;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_FUNC11_FALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode_switch && input_function == hcr_pkg::FUNC_RSCC && pin_fall && !host_ctl.gate_close)
		|=> (gate_state && count_value == 32'h0000_0000))
		else $error("function 11 fall did not clear and open");
	AST_FUNC11_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode_switch && input_function == hcr_pkg::FUNC_RSCC && pin_rise)
		|=> (!gate_state && capture == $past(count_value)))
		else $error("function 11 rise did not capture and close");
	AST_FUNC5: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode_switch && input_function == hcr_pkg::FUNC_RESET_RISE && pin_rise
		&& !host_ctl.gate_close && !host_ctl.gate_open)
		|=> (count_value == 32'h0000_0000 && gate_state == $past(gate_state)))
		else $error("function 5 did not reset or touched gate");
	AST_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(in_range(count_value, range0) && range0.set_mask[0] && !pulse_mode[0])
		|=> output_pattern[0])
		else $error("range did not set output bit");
	AST_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
		unit_read_command |=> (read_valid && read_data == $past(capture)))
		else $error("read did not return capture");
	AST_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pulse_pat[0] && pulse_cnt[0] == 32'h0000_0001 && !(level_pat[0] && !prev_level[0]))
		|=> !pulse_pat[0])
		else $error("pulse not released");
	AST_COMBINE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		combine_en |=> (first_digital_output == (output_pattern & $past(other_pattern))))
		else $error("combined output wrong");
	AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!gate_state && !host_ctl.sw_reset && !pin_rise && !pin_fall)
		|=> $stable(count_value))
		else $error("closed gate changed count");
	AST_SIMPLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!mode_switch && pin_fall && !host_ctl.gate_open && !host_ctl.gate_close
		&& !host_ctl.sw_reset)
		|=> gate_state == $past(gate_state))
		else $error("input function acted in simple mode");
endmodule

/* verif/hcr_field_model.sv */
`timescale 1ns/100ps
// encoder and sensor stand-in for the counter channel
module hcr_field_model (
	input wire logic sys_clk,
	output logic count_pulse,
	output logic sensor
);
	// ----------------------------------------
	// pins idle low at start
	// ----------------------------------------
	initial begin
		count_pulse = 1'h0;
		sensor = 1'h0;
	end

	// n encoder pulses, each wide enough for the synchroniser
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk) count_pulse <= 1'h1;
			repeat (2) @(posedge sys_clk);
			count_pulse <= 1'h0;
			repeat (1) @(posedge sys_clk);
		end
		repeat (6) @(posedge sys_clk);
	endtask

	// move the sensor pin, then let the edge settle
	task automatic set_sensor(input logic v);
		@(posedge sys_clk) sensor <= v;
		repeat (6) @(posedge sys_clk);
	endtask
endmodule

/* verif/hcr_top_tb_top.sv */
`timescale 1ns/100ps
// compare and count, report a mismatch at once
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fails++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module hcr_top_tb_top;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic count_pulse, sensor, mode_switch, combine_en, unit_read_command;
	logic [3:0] input_function;
	hcr_pkg::hcr_ctl_s host_ctl;
	hcr_pkg::hcr_range_s range0, range1;
	logic [1:0] pulse_mode, other_pattern, output_pattern, first_digital_output;
	logic [31:0] count_value, read_data;
	logic read_valid, gate_state;
	int fails = 0;
	int n_compared = 0;
	int hi;

	always #2 sys_clk = ~sys_clk;

	hcr_field_model i_hcr_field_model (.sys_clk(sys_clk), .count_pulse(count_pulse),
		.sensor(sensor));
	hcr_top #(.PULSE_CYCLES(32'h4)) i_hcr_top (.sys_clk(sys_clk), .rst_n(rst_n),
		.count_pulse(count_pulse), .first_digital_input(sensor),
		.input_function(input_function), .mode_switch(mode_switch), .host_ctl(host_ctl),
		.range0(range0), .range1(range1), .pulse_mode(pulse_mode), .combine_en(combine_en),
		.other_pattern(other_pattern), .unit_read_command(unit_read_command),
		.count_value(count_value), .read_data(read_data), .read_valid(read_valid),
		.gate_state(gate_state), .output_pattern(output_pattern),
		.first_digital_output(first_digital_output));

	// ----------------------------------------
	// host helpers
	// ----------------------------------------
	// one-cycle host control pulse
	task automatic host(input logic [2:0] c);
		@(posedge sys_clk) host_ctl <= hcr_pkg::hcr_ctl_s'(c);
		@(posedge sys_clk) host_ctl <= hcr_pkg::hcr_ctl_s'(3'h0);
		repeat (2) @(posedge sys_clk);
	endtask

	// simple counter: open counts, closed holds
	task automatic t_simple();
		host(3'h4);
		host(3'h2);
		i_hcr_field_model.pulses(3);
		`CHK("simple count", 32'h3, count_value)
		host(3'h1);
		i_hcr_field_model.pulses(2);
		`CHK("gate closed hold", 32'h3, count_value)
	endtask

	// function 11: clear on fall, capture and stop on rise, explicit read
	task automatic t_func11();
		mode_switch <= 1'h1;
		input_function <= 4'hb;
		i_hcr_field_model.set_sensor(1'h1);
		i_hcr_field_model.set_sensor(1'h0);
		`CHK("f11 cleared", 32'h0, count_value)
		`CHK("f11 gate open", 1'h1, gate_state)
		i_hcr_field_model.pulses(5);
		i_hcr_field_model.set_sensor(1'h1);
		`CHK("f11 gate closed", 1'h0, gate_state)
		i_hcr_field_model.pulses(2);
		`CHK("f11 held", 32'h5, count_value)
		@(posedge sys_clk) unit_read_command <= 1'h1;
		@(posedge sys_clk) unit_read_command <= 1'h0;
		#1;
		`CHK("read valid", 1'h1, read_valid)
		`CHK("captured", 32'h5, read_data)
	endtask

	// function 5: reset on rise, gate stays open
	task automatic t_func5();
		input_function <= 4'h5;
		i_hcr_field_model.set_sensor(1'h0);
		host(3'h2);
		i_hcr_field_model.pulses(3);
		i_hcr_field_model.set_sensor(1'h1);
		`CHK("f5 reset", 32'h0, count_value)
		i_hcr_field_model.pulses(2);
		`CHK("f5 keeps counting", 32'h2, count_value)
	endtask

	// ranges, combining and pulse shaping at count 2 then 1
	task automatic t_ranges();
		`CHK("range pattern", 2'h1, output_pattern)
		`CHK("range output", 2'h1, first_digital_output)
		combine_en <= 1'h1;
		other_pattern <= 2'h2;
		repeat (4) @(posedge sys_clk);
		`CHK("combine off", 2'h0, first_digital_output)
		other_pattern <= 2'h3;
		repeat (4) @(posedge sys_clk);
		`CHK("combine on", 2'h1, first_digital_output)
		pulse_mode <= 2'h1;
		host(3'h4);
		hi = 0;
		fork
			i_hcr_field_model.pulses(1);
			repeat (20) @(posedge sys_clk) hi += int'(output_pattern[0] === 1'h1);
		join
		`CHK("pulse width", 4, hi)
		`CHK("pulse released", 2'h0, output_pattern)
	endtask

	// new range bounds move the pattern to bit 1, combining masks it
	task automatic t_config();
		pulse_mode <= 2'h0;
		combine_en <= 1'h0;
		range0 <= '{low: 32'h5, high: 32'h6, set_mask: 2'h1};
		range1 <= '{low: 32'h1, high: 32'h1, set_mask: 2'h2};
		repeat (4) @(posedge sys_clk);
		`CHK("range1 pattern", 2'h2, output_pattern)
		`CHK("range1 output", 2'h2, first_digital_output)
		combine_en <= 1'h1;
		other_pattern <= 2'h1;
		repeat (4) @(posedge sys_clk);
		`CHK("combine bit1 off", 2'h0, first_digital_output)
		`CHK("combine keeps pattern", 2'h2, output_pattern)
	endtask

	// mid-run reset, then simple mode must ignore function 11 edges
	task automatic t_rerun();
		@(posedge sys_clk) rst_n <= 1'h0;
		mode_switch <= 1'h0;
		input_function <= 4'hb;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		@(posedge sys_clk);
		`CHK("rerun count", 32'h0, count_value)
		`CHK("rerun gate", 1'h0, gate_state)
		`CHK("rerun output", 2'h0, first_digital_output)
		host(3'h2);
		i_hcr_field_model.pulses(2);
		i_hcr_field_model.set_sensor(1'h0);
		`CHK("simple ignores fall count", 32'h2, count_value)
		`CHK("simple ignores fall gate", 1'h1, gate_state)
		i_hcr_field_model.set_sensor(1'h1);
		`CHK("simple ignores rise gate", 1'h1, gate_state)
		@(posedge sys_clk) unit_read_command <= 1'h1;
		@(posedge sys_clk) unit_read_command <= 1'h0;
		#1;
		`CHK("rerun read valid", 1'h1, read_valid)
		`CHK("simple no capture", 32'h0, read_data)
		@(posedge sys_clk);
		#1;
		`CHK("read valid one cycle", 1'h0, read_valid)
		host(3'h1);
	endtask

	// verdict and end of run
	task automatic summarize();
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		{mode_switch, combine_en, unit_read_command, input_function} = '0;
		host_ctl = hcr_pkg::hcr_ctl_s'(3'h0);
		range0 = '{low: 32'h1, high: 32'h2, set_mask: 2'h1};
		range1 = '{low: 32'h64, high: 32'hc8, set_mask: 2'h2};
		pulse_mode = 2'h0;
		other_pattern = 2'h0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'h1;
		#1;
		`CHK("reset count", 32'h0, count_value)
		`CHK("reset gate", 1'h0, gate_state)
		t_simple();
		t_func11();
		t_func5();
		t_ranges();
		t_config();
		t_rerun();
		summarize();
	end

	initial begin
		#20000;
		fails++;
		summarize();
	end
endmodule
